// [hw/tsisp_pkg.sv]
package tsisp_pkg;

  // ****************************************
  // Bus identity
  // ****************************************
  localparam logic [7:0] ID_BASE = 8'hA4;
  localparam int ID_FIXED_MSB = 7;
  localparam int ID_FIXED_LSB = 3;
  localparam int ID_SEL_HI_POS = 2;
  localparam int ID_SEL_LO_POS = 1;
  localparam int ID_DIR_POS = 0;

  // ****************************************
  // Register file
  // ****************************************
  localparam int REG_COUNT = 256;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] PTR_RESET_VAL = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int POWERUP_TIME_NS = 1000;
  localparam int POWERUP_CYCLES = (POWERUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ID,
    ST_ID_ACK,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } tsisp_state_t;

endpackage

// [hw/tsisp_slave.sv]
`timescale 1ns/10ps
module tsisp_slave (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic scl_clk_in,
  input wire logic sda_in,
  input wire logic address_select_hi_in,
  input wire logic address_select_lo_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic reg_wr_stb_out,
  output logic [7:0] reg_wr_addr_out,
  output logic [7:0] reg_wr_data_out,
  output logic bus_active_out
);

  // ****************************************
  // Serial clock domain: receive shifter
  // ****************************************
  logic [7:0] rx_shift_q;
  logic [7:0] rx_shift_d;

  // Bits are sampled on the master's rising clock edge, MSB first
  always_comb begin
    rx_shift_d = {rx_shift_q[6:0], sda_in};
  end

  always_ff @(posedge scl_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_shift_q <= 8'h00;
    end else begin
      rx_shift_q <= rx_shift_d;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] bus_s;
  logic [1:0] sel_s;
  logic scl_s;
  logic sda_s;

  tsisp_sync #(.WIDTH(2)) u_bus_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in({scl_clk_in, sda_in}),
    .sync_out(bus_s)
  );

  tsisp_sync #(.WIDTH(2)) u_sel_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .async_in({address_select_hi_in, address_select_lo_in}),
    .sync_out(sel_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  // ****************************************
  // Bus event detection
  // ****************************************
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Data edges while clock is high are START and STOP only
  always_comb begin
    scl_rise = scl_s && !scl_p_q;
    scl_fall = !scl_s && scl_p_q;
    start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
    stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;
  end

  // ****************************************
  // Power-up sequence and address capture
  // ****************************************
  logic [7:0] pwr_cnt_q;
  logic [7:0] pwr_cnt_d;
  logic ready_q;
  logic ready_d;
  logic [1:0] addr_sel_q;
  logic [1:0] addr_sel_d;

  always_comb begin
    pwr_cnt_d = pwr_cnt_q;
    ready_d = ready_q;
    addr_sel_d = addr_sel_q;
    if (!ready_q) begin
      if (pwr_cnt_q == 8'(tsisp_pkg::POWERUP_CYCLES - 1)) begin
        ready_d = 1'b1;
        addr_sel_d = sel_s;
      end else begin
        pwr_cnt_d = pwr_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_cnt_q <= 8'h00;
      ready_q <= 1'b0;
      addr_sel_q <= 2'h0;
    end else begin
      pwr_cnt_q <= pwr_cnt_d;
      ready_q <= ready_d;
      addr_sel_q <= addr_sel_d;
    end
  end

  // ****************************************
  // Protocol engine
  // ****************************************
  tsisp_pkg::tsisp_state_t state_q;
  tsisp_pkg::tsisp_state_t state_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic ack_on_q;
  logic ack_on_d;
  logic rw_q;
  logic rw_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic wr_en;
  logic id_match;
  logic [7:0] regs_q [tsisp_pkg::REG_COUNT];

  // Identity: fixed upper bits, pin bits, direction bit ignored
  always_comb begin
    id_match = (rx_shift_q[tsisp_pkg::ID_FIXED_MSB:tsisp_pkg::ID_FIXED_LSB] ==
                tsisp_pkg::ID_BASE[tsisp_pkg::ID_FIXED_MSB:tsisp_pkg::ID_FIXED_LSB]) &&
               (rx_shift_q[tsisp_pkg::ID_SEL_HI_POS] == addr_sel_q[1]) &&
               (rx_shift_q[tsisp_pkg::ID_SEL_LO_POS] == addr_sel_q[0]);
  end

  // rx_shift_q is only read on a synchronised rising edge: it settled
  // several fast-clock cycles earlier and stays until the next edge.
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    ack_on_d = ack_on_q;
    rw_d = rw_q;
    ptr_d = ptr_q;
    data_d = data_q;
    tx_d = tx_q;
    sda_oe_d = sda_oe_q;
    wr_en = 1'b0;
    if (!ready_q) begin
      state_d = tsisp_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
    end else if (start_ev) begin
      state_d = tsisp_pkg::ST_ID;
      bit_cnt_d = 3'h0;
      ack_on_d = 1'b0;
      sda_oe_d = 1'b0;
    end else if (stop_ev) begin
      state_d = tsisp_pkg::ST_IDLE;
      sda_oe_d = 1'b0;
      ack_on_d = 1'b0;
    end else begin
      unique case (state_q)
        tsisp_pkg::ST_IDLE, tsisp_pkg::ST_IGNORE: begin
          sda_oe_d = 1'b0;
        end
        tsisp_pkg::ST_ID, tsisp_pkg::ST_ADDR, tsisp_pkg::ST_WDATA: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == tsisp_pkg::LAST_BIT) begin
              unique case (state_q)
                tsisp_pkg::ST_ID: begin
                  rw_d = rx_shift_q[tsisp_pkg::ID_DIR_POS];
                  state_d = id_match ? tsisp_pkg::ST_ID_ACK : tsisp_pkg::ST_IGNORE;
                end
                tsisp_pkg::ST_ADDR: begin
                  ptr_d = rx_shift_q;
                  state_d = tsisp_pkg::ST_ADDR_ACK;
                end
                default: begin
                  data_d = rx_shift_q;
                  state_d = tsisp_pkg::ST_WDATA_ACK;
                end
              endcase
            end
          end
        end
        tsisp_pkg::ST_ID_ACK, tsisp_pkg::ST_ADDR_ACK, tsisp_pkg::ST_WDATA_ACK: begin
          if (scl_fall && !ack_on_q) begin
            sda_oe_d = 1'b1;
            ack_on_d = 1'b1;
          end else if (scl_fall) begin
            ack_on_d = 1'b0;
            sda_oe_d = 1'b0;
            bit_cnt_d = 3'h0;
            unique case (state_q)
              tsisp_pkg::ST_ID_ACK: begin
                if (rw_q) begin
                  tx_d = regs_q[ptr_q];
                  sda_oe_d = !regs_q[ptr_q][7];
                  state_d = tsisp_pkg::ST_RDATA;
                end else begin
                  state_d = tsisp_pkg::ST_ADDR;
                end
              end
              tsisp_pkg::ST_ADDR_ACK: begin
                state_d = tsisp_pkg::ST_WDATA;
              end
              default: begin
                wr_en = 1'b1;
                ptr_d = ptr_q + 8'h01;
                state_d = tsisp_pkg::ST_WDATA;
              end
            endcase
          end
        end
        tsisp_pkg::ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 3'h1;
            if (bit_cnt_q == tsisp_pkg::LAST_BIT) begin
              state_d = tsisp_pkg::ST_RACK;
            end
          end else if (scl_fall) begin
            tx_d = {tx_q[6:0], 1'b0};
            sda_oe_d = !tx_q[6];
          end
        end
        tsisp_pkg::ST_RACK: begin
          if (scl_fall && !ack_on_q) begin
            sda_oe_d = 1'b0;
          end else if (scl_rise) begin
            if (sda_s) begin
              state_d = tsisp_pkg::ST_IGNORE;
            end else begin
              ptr_d = ptr_q + 8'h01;
              ack_on_d = 1'b1;
            end
          end else if (scl_fall) begin
            ack_on_d = 1'b0;
            bit_cnt_d = 3'h0;
            tx_d = regs_q[ptr_q];
            sda_oe_d = !regs_q[ptr_q][7];
            state_d = tsisp_pkg::ST_RDATA;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= tsisp_pkg::ST_IDLE;
      bit_cnt_q <= 3'h0;
      ack_on_q <= 1'b0;
      rw_q <= 1'b0;
      ptr_q <= tsisp_pkg::PTR_RESET_VAL;
      data_q <= 8'h00;
      tx_q <= 8'h00;
      sda_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      ack_on_q <= ack_on_d;
      rw_q <= rw_d;
      ptr_q <= ptr_d;
      data_q <= data_d;
      tx_q <= tx_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // ****************************************
  // Register file and outputs
  // ****************************************
  logic wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic active_q;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < tsisp_pkg::REG_COUNT; i++) begin
        regs_q[i] <= tsisp_pkg::REG_RESET_VAL;
      end
    end else if (wr_en) begin
      regs_q[ptr_q] <= data_q;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      active_q <= 1'b0;
    end else begin
      wr_stb_q <= wr_en;
      wr_addr_q <= wr_en ? ptr_q : wr_addr_q;
      wr_data_q <= wr_en ? data_q : wr_data_q;
      active_q <= (state_d != tsisp_pkg::ST_IDLE);
    end
  end

  // Open drain: the pin value is always low, only the enable moves
  always_comb begin
    sda_out = 1'b0;
  end

  assign sda_oe_out = sda_oe_q;
  assign reg_wr_stb_out = wr_stb_q;
  assign reg_wr_addr_out = wr_addr_q;
  assign reg_wr_data_out = wr_data_q;
  assign bus_active_out = active_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence id_byte_ok;
    state_q == tsisp_pkg::ST_ID && scl_rise && bit_cnt_q == 3'h7 && id_match;
  endsequence

  sequence wbyte_done;
    (state_q == tsisp_pkg::ST_ADDR || state_q == tsisp_pkg::ST_WDATA) && scl_rise && bit_cnt_q == 3'h7;
  endsequence

  a_release_powerup: assert property (!ready_q |-> !sda_oe_q && state_q == tsisp_pkg::ST_IDLE)
    else $error("pin driven or busy during power-up");
  a_stop_to_idle: assert property (ready_q && stop_ev |=> state_q == tsisp_pkg::ST_IDLE)
    else $error("stop did not return to idle");
  a_id_ack_drive: assert property (id_byte_ok |=> !sda_oe_q ##[1:300] sda_oe_q)
    else $error("matching identification not acknowledged");
  a_id_mismatch: assert property (state_q == tsisp_pkg::ST_ID && scl_rise && bit_cnt_q == 3'h7 && !id_match
    && !start_ev && !stop_ev |=> state_q == tsisp_pkg::ST_IGNORE && !sda_oe_q)
    else $error("foreign identification answered");
  a_write_ack: assert property ((wbyte_done and (!start_ev && !stop_ev)) |-> ##[1:300] sda_oe_q)
    else $error("write byte not acknowledged");
  a_write_commit: assert property (wr_en |-> state_q == tsisp_pkg::ST_WDATA_ACK && ack_on_q && scl_fall
    ##1 regs_q[$past(ptr_q)] == $past(data_q))
    else $error("write stored outside its acknowledge");
  a_read_ptr_inc: assert property (state_q == tsisp_pkg::ST_RACK && scl_rise && !sda_s && ack_on_q == 1'b0
    && !start_ev && !stop_ev |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("read pointer did not advance");
  a_read_nack_end: assert property (state_q == tsisp_pkg::ST_RACK && scl_rise && sda_s && !start_ev && !stop_ev
    |=> state_q == tsisp_pkg::ST_IGNORE)
    else $error("read continued after missing acknowledge");
  a_read_msb: assert property (state_q == tsisp_pkg::ST_RDATA && $past(state_q) == tsisp_pkg::ST_RDATA
    && $stable(tx_q) |-> sda_oe_q == !tx_q[7])
    else $error("read bit does not follow shifter msb");
  a_change_low: assert property ($changed(sda_oe_q) && ready_q && !$past(start_ev) && !$past(stop_ev)
    |-> !scl_s)
    else $error("data pin moved while clock high");

endmodule

// [hw/tsisp_sync.sv]
`timescale 1ns/10ps
module tsisp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // ****************************************
  // Two flops; only the second reads the first
  // ****************************************
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// [tb/tsisp_master.sv]
`timescale 1ns/10ps
module tsisp_master (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  // ****************************************
  // Bit timing: scl low 75 ns, high 50 ns
  // ****************************************
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic bit_io(input logic b, output logic s);
    #25 sda_oe_out = ~b;
    #50 scl_out = 1'b1;
    #25 s = sda_in;
    #25 scl_out = 1'b0;
  endtask

  // Works from idle and, as repeated start, from scl low
  task automatic start_cond();
    if (scl_out) begin
      #25 sda_oe_out = 1'b1;
    end else begin
      #25 sda_oe_out = 1'b0;
      #50 scl_out = 1'b1;
      #50 sda_oe_out = 1'b1;
    end
    #50 scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    #25 sda_oe_out = 1'b1;
    #50 scl_out = 1'b1;
    #50 sda_oe_out = 1'b0;
    #200;
  endtask

  task automatic send_bits(input logic [7:0] d, input int n);
    logic s;
    for (int i = 7; i > 7 - n; i--) begin
      bit_io(d[i], s);
    end
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    send_bits(d, 8);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

// [tb/tsisp_slave_tb_top.sv]
`timescale 1ns/10ps
module tsisp_slave_tb_top;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sel_hi;
  logic sel_lo;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic sda_o;
  logic sda;
  logic wr_stb;
  logic bus_act;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [256];
  logic [15:0] notes [$];
  logic [15:0] nt;
  logic [6:0] dev;
  logic ack;
  int err_count = 0;
  int checks = 0;
  int seed = 21;

  always #5 clock_in = ~clock_in;
  // Open-drain data wire with pull-up
  assign sda = ~(m_oe | (sda_oe & ~sda_o));

  tsisp_master m (.sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

  tsisp_slave DUT (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .scl_clk_in(scl),
    .sda_in(sda),
    .address_select_hi_in(sel_hi),
    .address_select_lo_in(sel_lo),
    .sda_out(sda_o),
    .sda_oe_out(sda_oe),
    .reg_wr_stb_out(wr_stb),
    .reg_wr_addr_out(wr_addr),
    .reg_wr_data_out(wr_data),
    .bus_active_out(bus_act)
  );

  // ****************************************
  // Checking
  // ****************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(negedge clock_in) begin
    if (wr_stb === 1'b1) begin
      if (notes.size() == 0) begin
        check("store count", 8'h00, 8'h01);
      end else begin
        nt = notes.pop_front();
        check("store addr", nt[15:8], wr_addr);
        check("store data", nt[7:0], wr_data);
      end
    end
  end

  always @(sda_oe) begin
    if (rst_n_in === 1'b1) begin
      check("data change with scl high", 8'h00, {7'h00, scl});
    end
  end

  initial begin
    #400000;
    err_count++;
    $display("BAD watchdog expected done seen hang");
    results();
  end

  // ****************************************
  // Transfers
  // ****************************************
  task automatic head(input logic [7:0] a);
    m.start_cond();
    m.send_byte({dev, 1'b0}, ack);
    check("id ack", 8'h01, {7'h00, ack});
    check("active in transfer", 8'h01, {7'h00, bus_act});
    m.send_byte(a, ack);
    check("addr ack", 8'h01, {7'h00, ack});
  endtask

  task automatic write_n(input logic [7:0] a, input int n);
    logic [7:0] d;
    head(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      notes.push_back({a + 8'(i), d});
      mem[a + 8'(i)] = d;
      m.send_byte(d, ack);
      check("data ack", 8'h01, {7'h00, ack});
    end
    m.stop_cond();
    check("idle after write", 8'h00, {7'h00, bus_act});
  endtask

  task automatic read_n(input logic [7:0] a, input int n);
    logic [7:0] d;
    head(a);
    m.start_cond();
    m.send_byte({dev, 1'b1}, ack);
    check("read id ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i < n - 1, d);
      check("read data", mem[a + 8'(i)], d);
    end
    m.stop_cond();
    check("idle after read", 8'h00, {7'h00, bus_act});
  endtask

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sel_hi = 1'($random(seed));
    sel_lo = 1'($random(seed));
    dev = {5'h14, sel_hi, sel_lo};
    do_reset();
    @(negedge clock_in);
    check("oe after reset", 8'h00, {7'h00, sda_oe});
    // Start during power-up must be ignored
    // Odd offset keeps link edges off the system clock edges
    #103;
    m.start_cond();
    m.send_byte({dev, 1'b0}, ack);
    check("powerup id ack", 8'h00, {7'h00, ack});
    check("idle without start", 8'h00, {7'h00, bus_act});
    m.stop_cond();
    #1000;
    for (int k = 0; k < 4; k++) begin
      m.start_cond();
      m.send_byte({5'h14, k[1:0], 1'b0}, ack);
      check("id match ack", {7'h00, k[1:0] == {sel_hi, sel_lo}}, {7'h00, ack});
      m.send_byte(8'h5A, ack);
      check("next byte ack", {7'h00, k[1:0] == {sel_hi, sel_lo}}, {7'h00, ack});
      m.stop_cond();
    end
    write_n(8'h10, 3);
    write_n(8'hFF, 1);
    read_n(8'h10, 5);
    read_n(8'hFF, 1);
    // Stop in mid data byte discards the write
    write_n(8'h40, 1);
    head(8'h40);
    m.send_bits(8'hC3, 4);
    m.stop_cond();
    read_n(8'h40, 1);
    // Second reset brings registers back to default
    do_reset();
    #2003;
    read_n(8'h10, 2);
    check("pending stores", 8'h00, 8'(notes.size()));
    results();
  end
endmodule
